// [src/gsq_pkg.sv]
// shared constants, command codes and carriers for the status/ident query block
package gsq_pkg;
  // command opcodes presented by the parser on the command port
  localparam logic [4:0] CMD_NOP      = 5'h00;
  localparam logic [4:0] CMD_CHANNEL_DESCRIBE_QUERY_Q   = 5'h01;
  localparam logic [4:0] CMD_IDENT_Q  = 5'h02;
  localparam logic [4:0] CMD_IDN_Q    = 5'h03;
  localparam logic [4:0] CMD_WAIT     = 5'h04;
  localparam logic [4:0] CMD_ESE      = 5'h05;
  localparam logic [4:0] CMD_ESE_Q    = 5'h06;
  localparam logic [4:0] CMD_OPC      = 5'h07;
  localparam logic [4:0] CMD_SRE      = 5'h08;
  localparam logic [4:0] CMD_SRE_Q    = 5'h09;
  localparam logic [4:0] CMD_STB_Q    = 5'h0a;
  localparam logic [4:0] CMD_TST_Q    = 5'h0b;
  localparam logic [4:0] CMD_MCE      = 5'h0c;
  localparam logic [4:0] CMD_MCE_Q    = 5'h0d;
  localparam logic [4:0] CMD_ESR_Q    = 5'h0e;

  // response field kinds
  localparam logic [1:0] FLD_STRING   = 2'h0;
  localparam logic [1:0] FLD_INT      = 2'h1;

  // string selectors carried in a string field
  localparam logic [31:0] STR_MANUF      = 32'h0000_0001;
  localparam logic [31:0] STR_MODEL      = 32'h0000_0002;
  localparam logic [31:0] STR_MODEL_OPT  = 32'h0000_0003;
  localparam logic [31:0] STR_UNIT_SER   = 32'h0000_0004;
  localparam logic [31:0] STR_IDENT_NAME = 32'h0000_0005;

  // two-letter channel type codes, ascii packed
  localparam logic [15:0] channel_absent_code   = 16'h4e46;
  localparam logic [15:0] channel_bad_data_code = 16'h4e49;

  // status and event bit positions
  localparam int ESR_OPC_BIT  = 0;
  localparam int ESR_PON_BIT  = 7;
  localparam int STB_MCR_BIT  = 0;
  localparam int STB_MAV_BIT  = 4;
  localparam int STB_ESB_BIT  = 5;
  localparam int STB_MSS_BIT  = 6;
  localparam logic [7:0] SRE_ALLOWED = 8'h31;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] PON_MASK    = 8'h80;

  localparam int MC_W     = 8;
  localparam int CHAN_N   = 8;
  localparam int CHAN_W   = 3;

  localparam logic [2:0] IDN_FIELDS = 3'h6;
  localparam logic [2:0] CHANNEL_DESCRIBE_QUERY_FIELDS = 3'h2;
  localparam logic [2:0] ONE_FIELD  = 3'h1;

  typedef struct packed {
    logic [4:0]        op;
    logic [7:0]        arg;
    logic [CHAN_W-1:0] chan;
    logic              via_gpib;
  } gsq_cmd_t;

  typedef struct packed {
    logic [1:0]  kind;
    logic [31:0] value;
    logic        last;
  } gsq_field_t;

  typedef struct packed {
    logic        fitted;
    logic        valid;
    logic [15:0] type_code;
    logic [31:0] serial;
  } gsq_chan_t;
endpackage : gsq_pkg

// [src/gsq_status.sv]
// event status, enable masks and status byte composition
`timescale 1ns/1ps
module gsq_status (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // loads
  input  wire logic                 ese_load,
  input  wire logic                 sre_load,
  input  wire logic                 mce_load,
  input  wire logic [7:0]           load_val,
  // event sources
  input  wire logic [7:0]           esr_set,
  input  wire logic                 esr_clear,
  input  wire logic [gsq_pkg::MC_W-1:0] measurement_condition_flags,
  input  wire logic                 resp_pending,
  // state
  output logic [7:0]                esr,
  output logic [7:0]                event_status_enable_mask,
  output logic [7:0]                service_request_enable_mask,
  output logic [gsq_pkg::MC_W-1:0]  measurement_condition_enable,
  output logic [7:0]                stb,
  output logic                      srq
);
  import gsq_pkg::*;

  wire logic       esb      = |(esr & event_status_enable_mask);                           // R9
  wire logic       mcb      = |(measurement_condition_flags & measurement_condition_enable);   // R12
  wire logic [7:0] stb_base = {2'b00, esb, resp_pending, 3'b000, mcb}; // R13 R15
  wire logic       rqs      = |(stb_base & service_request_enable_mask & SRE_ALLOWED);        // R11 R23

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      esr <= PON_MASK;                                                // R22
      event_status_enable_mask <= REG_RESET;
      service_request_enable_mask <= REG_RESET;
      measurement_condition_enable <= '0;
    end else begin
      // set beats clear so no event is lost on read
      esr <= (esr_clear ? REG_RESET : esr) | esr_set;                // R21
      if (ese_load) event_status_enable_mask <= load_val;                                  // R8
      if (sre_load) service_request_enable_mask <= load_val;
      if (mce_load) measurement_condition_enable <= load_val[MC_W-1:0];                        // R17
    end
  end

  always_comb begin
    stb = stb_base;
    stb[STB_MSS_BIT] = rqs;                                           // R14
  end
  assign srq = rqs;

  property p_esb;
    @(posedge mclk) disable iff (rst) (|(esr & event_status_enable_mask)) |-> stb[STB_ESB_BIT];
  endproperty
  a_esb: assert property (p_esb) else $error("summary bit missing"); // R9

  property p_mss;
    @(posedge mclk) disable iff (rst) stb[STB_MSS_BIT] == (|(stb & service_request_enable_mask & SRE_ALLOWED));
  endproperty
  a_mss: assert property (p_mss) else $error("master summary wrong"); // R14

  property p_mav;
    @(posedge mclk) disable iff (rst) stb[STB_MAV_BIT] == resp_pending;
  endproperty
  a_mav: assert property (p_mav) else $error("message bit wrong"); // R13

  property p_mcb;
    @(posedge mclk) disable iff (rst)
      stb[STB_MCR_BIT] == (|(measurement_condition_flags & measurement_condition_enable));
  endproperty
  a_mcb: assert property (p_mcb) else $error("condition bit wrong"); // R12

  property p_ese_load;
    @(posedge mclk) disable iff (rst) ese_load |=> event_status_enable_mask == $past(load_val);
  endproperty
  a_ese_load: assert property (p_ese_load) else $error("ese not loaded"); // R8

  property p_esr_keep_set;
    @(posedge mclk) disable iff (rst) (esr_set != 8'h00) |=> ((esr & $past(esr_set)) == $past(esr_set));
  endproperty
  a_esr_keep_set: assert property (p_esr_keep_set) else $error("event lost"); // R21
endmodule : gsq_status

// [src/gsq_query.sv]
// command interpreter for ident queries and gpib status commands
`timescale 1ns/1ps
// Operation
// [R1] channel query returns type then serial
// [R2] absent or bad channel uses special codes
// [R3] identity-name query returns configured name
// [R4] id query returns six fields in order
// [R5] model gets option suffix when installed
// [R6] status commands act only over gpib
// [R7] wait accepted, no error, no action
// [R8] ese command loads event enable mask
// [R9] enabled event bits set summary bit five
// [R10] operation complete sets event bit zero
// [R11] sre bits 0,4,5 allow service request
// [R12] enabled condition bits set status bit zero
// [R13] status bit four while response pending
// [R14] bit six is master summary status
// [R15] status byte query returns composed byte
// [R16] self-test query returns zero, does nothing
// [R17] mce command loads condition enable mask
// [R18] mce readback returns mask unchanged
// [R19] sre readback returns mask unchanged
// [R20] ese readback returns mask unchanged
// [R21] event query returns then clears register
// [R22] power bit set at reset and enable
// [R23] service request when enabled bits set
module gsq_query (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // command port
  input  wire logic                     cmd_valid,
  output logic                          cmd_ready,
  input  wire gsq_pkg::gsq_cmd_t        cmd,
  // response field stream
  output logic                          rsp_valid,
  input  wire logic                     rsp_ready,
  output gsq_pkg::gsq_field_t           rsp,
  output logic                          cmd_error,
  // unit configuration
  input  wire gsq_pkg::gsq_chan_t [gsq_pkg::CHAN_N-1:0] chan_info,
  input  wire logic [31:0]              fw_major,
  input  wire logic [31:0]              fw_minor,
  input  wire logic [31:0]              fw_build,
  input  wire logic                     option_installed,
  input  wire logic                     gpib_enabled,
  input  wire logic [gsq_pkg::MC_W-1:0] measurement_condition_flags,
  // status out
  output logic [7:0]                    status_byte,
  output logic                          srq
);
  import gsq_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_DONE = 3'b100
  } gsq_state_t;

  gsq_state_t state;
  gsq_state_t next_state;
  gsq_cmd_t   held;
  logic [2:0] idx;
  logic [2:0] count;
  logic [7:0] esr, event_status_enable_mask, service_request_enable_mask, stb;
  logic [MC_W-1:0] measurement_condition_enable;
  logic [7:0] snap;
  logic       en_q1, en_q2, en_q3;
  logic       en_seen;
  logic       cmd_error_r;

  function automatic logic is_gpib_only(input logic [4:0] op);
    is_gpib_only = (op >= CMD_WAIT) && (op <= CMD_ESR_Q);
  endfunction

  function automatic logic is_query(input logic [4:0] op);
    case (op)
      CMD_CHANNEL_DESCRIBE_QUERY_Q, CMD_IDENT_Q, CMD_IDN_Q, CMD_ESE_Q, CMD_SRE_Q,
      CMD_STB_Q, CMD_TST_Q, CMD_MCE_Q, CMD_ESR_Q: is_query = 1'b1;
      default: is_query = 1'b0;
    endcase
  endfunction

  wire logic take      = cmd_valid && cmd_ready;
  wire logic allowed   = !is_gpib_only(cmd.op) || cmd.via_gpib;          // R6
  wire logic known     = (cmd.op != CMD_NOP) && (cmd.op <= CMD_ESR_Q);
  wire logic accept    = take && allowed && known;
  wire logic bad       = take && !(allowed && known);
  wire logic start_q   = accept && is_query(cmd.op);
  wire logic ese_load  = accept && (cmd.op == CMD_ESE);                  // R8
  wire logic sre_load  = accept && (cmd.op == CMD_SRE);                  // R11
  wire logic mce_load  = accept && (cmd.op == CMD_MCE);                  // R17
  wire logic opc_cmd   = accept && (cmd.op == CMD_OPC);                  // R10
  wire logic esr_read  = accept && (cmd.op == CMD_ESR_Q);                // R21
  wire logic en_agree  = (en_q2 == en_q3);
  wire logic en_rise   = en_agree && en_q3 && !en_seen;                   // R22
  wire logic [7:0] esr_set = (opc_cmd ? (8'h01 << ESR_OPC_BIT) : 8'h00) |
                             (en_rise ? PON_MASK : 8'h00);              // R22
  wire logic resp_pending = (state != ST_IDLE);                          // R13
  wire logic sending      = (state == ST_SEND);
  wire gsq_chan_t sel_ch  = chan_info[held.chan];
  wire logic last_fld     = (idx == count - ONE_FIELD);

  assign cmd_ready = (state == ST_IDLE);

  gsq_status u_status (
    .mclk                        (mclk),
    .rst                         (rst),
    .ese_load                    (ese_load),
    .sre_load                    (sre_load),
    .mce_load                    (mce_load),
    .load_val                    (cmd.arg),
    .esr_set                     (esr_set),
    .esr_clear                   (esr_read),
    .measurement_condition_flags (measurement_condition_flags),
    .resp_pending                (resp_pending),
    .esr                         (esr),
    .event_status_enable_mask                         (event_status_enable_mask),
    .service_request_enable_mask                         (service_request_enable_mask),
    .measurement_condition_enable                         (measurement_condition_enable),
    .stb                         (stb),
    .srq                         (srq)
  );

  // response field selection
  always_comb begin
    rsp.kind  = FLD_INT;
    rsp.value = 32'h0;
    rsp.last  = last_fld;
    case (held.op)
      CMD_CHANNEL_DESCRIBE_QUERY_Q: begin
        if (idx == 3'h0) begin                                             // R1
          rsp.kind  = FLD_STRING;
          rsp.value = {16'h0, !sel_ch.fitted ? channel_absent_code :       // R2
                              !sel_ch.valid  ? channel_bad_data_code :
                              sel_ch.type_code};
        end else begin
          rsp.value = sel_ch.serial;
        end
      end
      CMD_IDENT_Q: begin
        rsp.kind  = FLD_STRING;
        rsp.value = STR_IDENT_NAME;                                        // R3
      end
      CMD_IDN_Q: begin
        case (idx)                                                         // R4
          3'h0: begin rsp.kind = FLD_STRING; rsp.value = STR_MANUF; end
          3'h1: begin
            rsp.kind  = FLD_STRING;
            rsp.value = option_installed ? STR_MODEL_OPT : STR_MODEL;      // R5
          end
          3'h2: begin rsp.kind = FLD_STRING; rsp.value = STR_UNIT_SER; end
          3'h3: rsp.value = fw_major;
          3'h4: rsp.value = fw_minor;
          default: rsp.value = fw_build;
        endcase
      end
      CMD_ESE_Q, CMD_SRE_Q, CMD_MCE_Q, CMD_STB_Q, CMD_ESR_Q:
        rsp.value = {24'h0, snap};                                         // R15 R18 R19 R20
      CMD_TST_Q: rsp.value = 32'h0;                                        // R16
      default: rsp.value = 32'h0;
    endcase
  end

  assign rsp_valid = sending;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (start_q) next_state = ST_SEND;
      ST_SEND: if (rsp_ready && last_fld) next_state = ST_DONE;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  wire logic [2:0] next_count = (cmd.op == CMD_IDN_Q)  ? IDN_FIELDS :
                                (cmd.op == CMD_CHANNEL_DESCRIBE_QUERY_Q) ? CHANNEL_DESCRIBE_QUERY_FIELDS : ONE_FIELD;
  wire logic [7:0] next_snap  = (cmd.op == CMD_ESE_Q) ? event_status_enable_mask :
                                (cmd.op == CMD_SRE_Q) ? service_request_enable_mask :
                                (cmd.op == CMD_MCE_Q) ? 8'(measurement_condition_enable) :
                                (cmd.op == CMD_STB_Q) ? stb :
                                (cmd.op == CMD_ESR_Q) ? esr : 8'h00;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      held  <= '0;
      idx   <= 3'h0;
      count <= 3'h0;
      snap  <= 8'h00;
    end else begin
      state <= next_state;
      if (start_q) begin
        held  <= cmd;
        idx   <= 3'h0;
        count <= next_count;
        snap  <= next_snap;
      end else if (sending && rsp_ready) begin
        idx <= idx + 3'h1;
      end
    end
  end

  // enable pin crosses in; change counts once second and third agree
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // reset to the enabled level: power on already sets the bit
      en_q1 <= 1'b1;
      en_q2 <= 1'b1;
      en_q3 <= 1'b1;
      en_seen <= 1'b1;
      cmd_error_r <= 1'b0;
    end else begin
      en_q1 <= gpib_enabled;
      en_q2 <= en_q1;
      en_q3 <= en_q2;
      if (en_agree) en_seen <= en_q3;
      // wait is accepted without error and does nothing else
      cmd_error_r <= bad;                                                  // R7
    end
  end

  assign cmd_error   = cmd_error_r;
  assign status_byte = stb;

  property p_opc;
    @(posedge mclk) disable iff (rst) opc_cmd |=> esr[ESR_OPC_BIT];
  endproperty
  a_opc: assert property (p_opc) else $error("opc bit not set"); // R10

  property p_gpib_only;
    @(posedge mclk) disable iff (rst)
      (take && is_gpib_only(cmd.op) && !cmd.via_gpib) |=> cmd_error && state == ST_IDLE;
  endproperty
  a_gpib_only: assert property (p_gpib_only) else $error("non-gpib status cmd acted"); // R6

  property p_wait;
    @(posedge mclk) disable iff (rst)
      (take && cmd.op == CMD_WAIT && cmd.via_gpib) |=> !cmd_error && state == ST_IDLE;
  endproperty
  a_wait: assert property (p_wait) else $error("wait misbehaved"); // R7

  sequence s_idn_go;
    take && allowed && cmd.op == CMD_IDN_Q;
  endsequence
  property p_idn_six;
    @(posedge mclk) disable iff (rst) s_idn_go |=> count == IDN_FIELDS;
  endproperty
  a_idn_six: assert property (p_idn_six) else $error("id field count wrong"); // R4

  property p_tst;
    @(posedge mclk) disable iff (rst)
      (sending && held.op == CMD_TST_Q) |-> rsp.value == 32'h0 && rsp.last;
  endproperty
  a_tst: assert property (p_tst) else $error("self test nonzero"); // R16

  property p_esr_clear;
    @(posedge mclk) disable iff (rst)
      (esr_read && esr_set == 8'h00) |=> esr == 8'h00;
  endproperty
  a_esr_clear: assert property (p_esr_clear) else $error("event reg not cleared"); // R21

  property p_channel_describe_query_absent;
    @(posedge mclk) disable iff (rst)
      (sending && held.op == CMD_CHANNEL_DESCRIBE_QUERY_Q && idx == 3'h0 && !sel_ch.fitted)
        |-> rsp.value[15:0] == channel_absent_code;
  endproperty
  a_channel_describe_query_absent: assert property (p_channel_describe_query_absent) else $error("absent code wrong"); // R2

  property p_sre_rb;
    @(posedge mclk) disable iff (rst)
      (take && allowed && cmd.op == CMD_SRE_Q) |=> snap == $past(service_request_enable_mask) && service_request_enable_mask == $past(service_request_enable_mask);
  endproperty
  a_sre_rb: assert property (p_sre_rb) else $error("sre readback wrong"); // R19
endmodule : gsq_query

// [verification/gsq_host.sv]
// remote controller model that drains the response field stream
`timescale 1ns/1ps
module gsq_host (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // pacing: 0 prompt, 1 every other cycle, 2 stalled
  input  wire logic [1:0]          mode,
  // response field stream
  input  wire logic                rsp_valid,
  input  wire gsq_pkg::gsq_field_t rsp,
  output logic                     rsp_ready
);
  import gsq_pkg::*;
  gsq_field_t fq[$];
  logic       tog;

  // a field counts only at an edge where both sides agree
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_ready <= 1'b0;
      tog       <= 1'b0;
    end else begin
      tog       <= ~tog;
      rsp_ready <= (mode == 2'h0) || (mode == 2'h1 && tog);
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
        fq.push_back(rsp);
      end
    end
  end
endmodule : gsq_host

// [verification/gsq_query_tb.sv]
// self-checking bench for the ident query and gpib status interpreter
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (b)); end end
module gsq_query_tb;
  import gsq_pkg::*;
  logic                     mclk, rst, cmd_valid, option_installed, gpib_enabled;
  gsq_cmd_t                 cmd;
  gsq_chan_t [CHAN_N-1:0]   chan_info;
  logic [31:0]              fw_major, fw_minor, fw_build;
  logic [MC_W-1:0]          mcf;
  logic                     cmd_ready, rsp_valid, rsp_ready, cmd_error, srq;
  gsq_field_t               rsp;
  logic [7:0]               status_byte;
  logic [1:0]               host_mode;
  int                       n_mismatch, cmp_count, n_err, ch;

  gsq_query i_gsq_query (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .cmd_error(cmd_error),
    .chan_info(chan_info), .fw_major(fw_major), .fw_minor(fw_minor), .fw_build(fw_build),
    .option_installed(option_installed), .gpib_enabled(gpib_enabled),
    .measurement_condition_flags(mcf), .status_byte(status_byte), .srq(srq));
  gsq_host i_gsq_host (.mclk(mclk), .rst(rst), .mode(host_mode), .rsp_valid(rsp_valid),
    .rsp(rsp), .rsp_ready(rsp_ready));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // error pulses last one cycle, so they are tallied at every edge
  always @(posedge mclk) if (cmd_error === 1'b1) n_err++;

  task automatic stop_test();
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic send(input logic [4:0] op, input logic [7:0] arg, input logic [2:0] c,
                      input logic gp);
    gsq_cmd_t k;
    int       n;
    k = '{op: op, arg: arg, chan: c, via_gpib: gp};
    i_gsq_host.fq.delete();
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd       <= k;
    n = 0;
    @(negedge mclk);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    if (n == 50) n_mismatch++;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd       <= ~k;
  endtask : send

  task automatic query(input logic [4:0] op, input logic [2:0] c, input logic gp, input int n);
    int w;
    send(op, 8'h00, c, gp);
    w = 0;
    while (i_gsq_host.fq.size() < n && w < 100) begin
      @(negedge mclk);
      w++;
    end
    if (w == 100) n_mismatch++;
  endtask : query

  task automatic chk_f(input int i, input logic [1:0] kd, input logic [31:0] v, input logic l);
    gsq_field_t e;
    e = '{kind: kd, value: v, last: l};
    `CHK(i_gsq_host.fq[i], e)
  endtask : chk_f

  task automatic qint(input logic [4:0] op, input logic [7:0] v);
    query(op, 3'h0, 1'b1, 1);
    chk_f(0, FLD_INT, {24'h0, v}, 1'b1);
  endtask : qint

  // three falling edges clear the one-cycle ST_DONE wind-down after a query
  task automatic chk_stb(input logic [7:0] v, input logic s);
    repeat (3) @(negedge mclk);
    `CHK(status_byte, v)
    `CHK(srq, s)
  endtask : chk_stb

  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    rst = 1'b1; cmd_valid = 1'b0; cmd = '0; option_installed = 1'b0; gpib_enabled = 1'b1;
    mcf = '0; host_mode = 2'h0; chan_info = '0;
    fw_major = 32'h0000_0003; fw_minor = 32'h0000_0011; fw_build = 32'h0000_0203;
    chan_info[1] = '{fitted: 1'b1, valid: 1'b0, type_code: 16'h4344, serial: 32'h0000_0022};
    chan_info[2] = '{fitted: 1'b1, valid: 1'b1, type_code: 16'h4546, serial: 32'h0000_0033};
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    qint(CMD_ESR_Q, 8'h80);
    qint(CMD_ESR_Q, 8'h00);
    send(CMD_ESE, 8'h21, 3'h0, 1'b1);
    qint(CMD_ESE_Q, 8'h21);
    send(CMD_ESE, 8'hff, 3'h0, 1'b0);
    qint(CMD_ESE_Q, 8'h21);
    `CHK(n_err, 1)
    send(5'h1f, 8'h00, 3'h0, 1'b1);
    send(CMD_WAIT, 8'h00, 3'h0, 1'b1);
    chk_stb(8'h00, 1'b0);
    `CHK(n_err, 2)
    send(CMD_OPC, 8'h00, 3'h0, 1'b1);
    chk_stb(8'h20, 1'b0);
    send(CMD_SRE, 8'h20, 3'h0, 1'b1);
    chk_stb(8'h60, 1'b1);
    qint(CMD_SRE_Q, 8'h20);
    qint(CMD_STB_Q, 8'h60);
    qint(CMD_ESR_Q, 8'h01);
    chk_stb(8'h00, 1'b0);
    send(CMD_MCE, 8'h05, 3'h0, 1'b1);
    qint(CMD_MCE_Q, 8'h05);
    @(posedge mclk) mcf <= 8'h04;
    chk_stb(8'h01, 1'b0);
    send(CMD_SRE, 8'h01, 3'h0, 1'b1);
    chk_stb(8'h41, 1'b1);
    @(posedge mclk) mcf <= 8'h02;
    chk_stb(8'h00, 1'b0);
    send(CMD_SRE, 8'h10, 3'h0, 1'b1);
    @(posedge mclk) host_mode <= 2'h2;
    send(CMD_TST_Q, 8'h00, 3'h0, 1'b1);
    chk_stb(8'h50, 1'b1);
    `CHK(rsp_valid, 1'b1)
    @(posedge mclk) host_mode <= 2'h0;
    repeat (4) @(negedge mclk);
    chk_f(0, FLD_INT, 32'h0, 1'b1);
    chk_stb(8'h00, 1'b0);
    @(posedge mclk) host_mode <= 2'h1;
    for (int o = 0; o < 2; o++) begin
      @(posedge mclk) option_installed <= o[0];
      query(CMD_IDN_Q, 3'h0, 1'b0, 6);
      chk_f(0, FLD_STRING, STR_MANUF, 1'b0);
      chk_f(1, FLD_STRING, (o == 1) ? STR_MODEL_OPT : STR_MODEL, 1'b0);
      chk_f(2, FLD_STRING, STR_UNIT_SER, 1'b0);
      chk_f(3, FLD_INT, fw_major, 1'b0);
      chk_f(4, FLD_INT, fw_minor, 1'b0);
      chk_f(5, FLD_INT, fw_build, 1'b1);
    end
    query(CMD_IDENT_Q, 3'h0, 1'b0, 1);
    chk_f(0, FLD_STRING, STR_IDENT_NAME, 1'b1);
    for (ch = 0; ch < 3; ch++) begin
      query(CMD_CHANNEL_DESCRIBE_QUERY_Q, ch[2:0], 1'b0, 2);
      chk_f(0, FLD_STRING, {16'h0, (ch == 0) ? channel_absent_code :
            (ch == 1) ? channel_bad_data_code : 16'h4546}, 1'b0);
      if (ch == 2) chk_f(1, FLD_INT, 32'h0000_0033, 1'b1);
    end
    @(posedge mclk) gpib_enabled <= 1'b0;
    repeat (8) @(posedge mclk);
    gpib_enabled <= 1'b1;
    repeat (8) @(posedge mclk);
    @(posedge mclk) host_mode <= 2'h0;
    qint(CMD_ESR_Q, 8'h80);
    send(CMD_SRE, 8'hff, 3'h0, 1'b1);
    qint(CMD_SRE_Q, 8'hff);
    `CHK(n_err, 2)
    stop_test();
  end
endmodule : gsq_query_tb
